// File: hw/pll_multiplier_prescaler_regs.sv
/*
  PLL multiplier-select and input prescaler registers on the I/O register map, with the settings
  they give the clock generator: the multiplier factor, its validity and the prescaler divide ratio.
  Assumes a synchronous I/O port on the system clock: one-cycle write and read strobes qualified by
  the address, write data valid with the write strobe, and read data returned one cycle after the read.
  Assumes the PLL and the prescaler divider sit outside and only consume these settings.
*/
`timescale 1ns/1ps
`include "pll_mult_prescale_params.svh"

module pll_multiplier_prescaler_regs
  import pll_mult_prescale_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [15:0] io_addr_in,
  input wire logic io_write_in,
  input wire logic [15:0] io_wdata_in,
  input wire logic io_read_in,
  output logic [15:0] io_rdata_out,
  output logic io_hit_out,
  output logic [4:0] pll_multiplier_select_out,
  output logic mult_code_valid_out,
  output logic [4:0] prescaler_ratio_out,
  output logic prescaler_enable_out,
  output logic [5:0] prescale_divide_out,
  output logic [3:0] pll_factor_out
);

  field5_t mult_reg;
  field5_t mult_next;
  field5_t ratio_reg;
  field5_t ratio_next;
  logic enable_reg;
  logic enable_next;
  logic valid_reg;
  logic valid_next;
  logic [3:0] factor_reg;
  logic [3:0] factor_next;
  divide_t divide_reg;
  divide_t divide_next;
  io_word_t rdata_reg;
  io_word_t rdata_next;
  field5_t wdata_field;
  logic wdata_enable;
  logic hit_mult;
  logic hit_div;
  logic write_mult;
  logic write_div;
  logic read_mult;
  logic read_div;
  logic read_none;

  assign hit_mult = (io_addr_in == `MULT_CTRL_ADDR);
  assign hit_div = (io_addr_in == `PRESCALE_DIV_ADDR);
  assign io_hit_out = hit_mult | hit_div;

  assign write_mult = io_write_in & hit_mult;
  assign write_div = io_write_in & hit_div;
  assign read_mult = io_read_in & hit_mult;
  assign read_div = io_read_in & hit_div;
  assign read_none = io_read_in & ~hit_mult & ~hit_div;

  // used write bits
  // Only the documented fields are taken from the write word, so writes to reserved bits are lost here.
  assign wdata_field = io_wdata_in[`FIELD_MSB:`FIELD_LSB];
  assign wdata_enable = io_wdata_in[`ENABLE_BIT];

  always_comb begin
    mult_next = mult_reg;
    if (write_mult) begin
      mult_next = wdata_field;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      mult_reg <= `MULT_SELECT_RESET;
    end else begin
      mult_reg <= mult_next;
    end
  end

  always_comb begin
    ratio_next = ratio_reg;
    if (write_div) begin
      ratio_next = wdata_field;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ratio_reg <= `PRESCALE_RATIO_RESET;
    end else begin
      ratio_reg <= ratio_next;
    end
  end

  always_comb begin
    enable_next = enable_reg;
    if (write_div) begin
      enable_next = wdata_enable;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      enable_reg <= `PRESCALE_ENABLE_RESET;
    end else begin
      enable_reg <= enable_next;
    end
  end

  // reserved code flag
  // Reserved codes are stored as written so software can read back what it wrote.
  always_comb begin
    valid_next = (mult_next >= `MULT_CODE_MIN) && (mult_next <= `MULT_CODE_MAX);
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      valid_reg <= `MULT_VALID_RESET;
    end else begin
      valid_reg <= valid_next;
    end
  end

  // locked output factor
  // A reserved code yields zero so the PLL is never handed an undefined ratio.
  always_comb begin
    factor_next = `PLL_FACTOR_RESERVED;
    if (valid_next) begin
      factor_next = mult_next[3:0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      factor_reg <= `PLL_FACTOR_RESET;
    end else begin
      factor_reg <= factor_next;
    end
  end

  // prescaler divide ratio
  // A disabled prescaler passes the reference straight through, which counts as divide by one.
  always_comb begin
    divide_next = `BYPASS_DIVIDE;
    if (enable_next) begin
      divide_next = {1'h0, ratio_next} + 6'h01;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      divide_reg <= `PRESCALE_DIVIDE_RESET;
    end else begin
      divide_reg <= divide_next;
    end
  end

  always_comb begin
    rdata_next = rdata_reg;
    if (read_mult) begin
      rdata_next = 16'h0000;
      rdata_next[`FIELD_MSB:`FIELD_LSB] = mult_reg;
    end else if (read_div) begin
      rdata_next = 16'h0000;
      rdata_next[`FIELD_MSB:`FIELD_LSB] = ratio_reg;
      rdata_next[`ENABLE_BIT] = enable_reg;
    end else if (read_none) begin
      rdata_next = 16'h0000;
    end
  end

  // registered read data
  // The read word is built from the state before the edge, so a read beside a write returns the old value.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rdata_reg <= `READ_DATA_RESET;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // The settings leave from flip-flops, so the clock generator never sees a decode glitch.
  // read data output
  assign io_rdata_out = rdata_reg;

  assign pll_multiplier_select_out = mult_reg;
  assign mult_code_valid_out = valid_reg;

  assign prescaler_ratio_out = ratio_reg;
  assign prescaler_enable_out = enable_reg;
  assign prescale_divide_out = divide_reg;

  assign pll_factor_out = factor_reg;

endmodule

// File: hw/pll_mult_prescale_params.svh
/*
  Offsets, field positions, reset values and codes for the PLL multiplier and prescaler registers.
  Assumes it is included by bare name from files under hw/.
*/
`ifndef PLL_MULT_PRESCALE_PARAMS_SVH
`define PLL_MULT_PRESCALE_PARAMS_SVH

`define MULT_CTRL_ADDR 16'h1C88
`define PRESCALE_DIV_ADDR 16'h1C8A
`define FIELD_MSB 4
`define FIELD_LSB 0
`define ENABLE_BIT 15
`define MULT_SELECT_RESET 5'h00
`define PRESCALE_RATIO_RESET 5'h00
`define PRESCALE_ENABLE_RESET 1'h1
`define MULT_VALID_RESET 1'h0
`define PLL_FACTOR_RESET 4'h0
`define PRESCALE_DIVIDE_RESET 6'h01
`define READ_DATA_RESET 16'h0000
`define MULT_CODE_MIN 5'h02
`define MULT_CODE_MAX 5'h0F
`define PLL_FACTOR_RESERVED 4'h0
`define BYPASS_DIVIDE 6'h01

`endif

// File: hw/pll_mult_prescale_pkg.sv
/*
  Types shared by the PLL multiplier and prescaler register block.
  Assumes no surroundings beyond a SystemVerilog compiler.
*/
package pll_mult_prescale_pkg;
  typedef logic [4:0] field5_t;
  typedef logic [15:0] io_word_t;
  typedef logic [5:0] divide_t;
endpackage

// File: test/pll_regs_properties.sv
/* Checker for the PLL multiplier and prescaler registers.
   Assumes the block's port names and one clock. */
`timescale 1ns/1ps
module pll_regs_properties (
  input wire logic sys_clk_in, rst_in, io_write_in, io_read_in, prescaler_enable_out, io_hit_out, mult_code_valid_out,
  input wire logic [15:0] io_addr_in, io_wdata_in, io_rdata_out,
  input wire logic [4:0] pll_multiplier_select_out, prescaler_ratio_out,
  input wire logic [5:0] prescale_divide_out,
  input wire logic [3:0] pll_factor_out);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  wire logic am = io_addr_in == 16'h1C88;
  wire logic ap = io_addr_in == 16'h1C8A;
  sequence s_mult_write;
    io_write_in && am;
  endsequence
  sequence s_ratio_write;
    io_write_in && ap;
  endsequence
  chk_mult_write: assert property (s_mult_write |=> {11'h000, pll_multiplier_select_out} ==
    ($past(io_wdata_in) & 16'h001F)) else $error("multiplier write lost");
  chk_ratio_write: assert property (s_ratio_write |=> {prescaler_enable_out, 10'h000, prescaler_ratio_out} ==
    ($past(io_wdata_in) & 16'h801F)) else $error("prescaler write lost");
  chk_read_mult: assert property (io_read_in && am |=> io_rdata_out ==
    {11'h000, $past(pll_multiplier_select_out)}) else $error("multiplier read wrong");
  chk_read_ratio: assert property (io_read_in && ap |=> io_rdata_out ==
    {$past(prescaler_enable_out), 10'h000, $past(prescaler_ratio_out)}) else $error("prescaler read wrong");
  chk_read_none: assert property (io_read_in && !am && !ap |=> io_rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!io_read_in |=> $stable(io_rdata_out)) else $error("read data moved");
  chk_divide_ratio: assert property (prescale_divide_out == (prescaler_enable_out ?
    {1'h0, prescaler_ratio_out} + 6'h01 : 6'h01)) else $error("divide ratio wrong");
  chk_factor_code: assert property (pll_factor_out == (pll_multiplier_select_out inside {[5'h02:5'h0F]} ?
    pll_multiplier_select_out[3:0] : 4'h0)) else $error("factor wrong");
  chk_hit_decode: assert property (io_hit_out == (am || ap)) else $error("address decode wrong");
  chk_valid_flag: assert property (mult_code_valid_out == (pll_multiplier_select_out inside {[5'h02:5'h0F]}))
    else $error("valid flag wrong");
endmodule
bind pll_multiplier_prescaler_regs pll_regs_properties u_chk (.*);

// File: test/pll_multiplier_prescaler_regs_test.sv
/* Bench for the PLL register block.
   Assumes the design and checker are compiled first. */
`timescale 1ns/1ps
module pll_multiplier_prescaler_regs_test;
  logic sys_clk_in = 1'h0, rst_in = 1'h1, io_write_in = 1'h0, io_read_in = 1'h0;
  logic io_hit_out, mult_code_valid_out, prescaler_enable_out;
  logic [15:0] io_addr_in = 16'h0000, io_wdata_in = 16'h0000, io_rdata_out;
  logic [4:0] pll_multiplier_select_out, prescaler_ratio_out;
  logic [5:0] prescale_divide_out;
  logic [3:0] pll_factor_out;
  int bad_count = 0, checked = 0;
  // Columns: address, write data, read back, divide, valid flag beside factor.
  logic [15:0] rows [7][5] = '{'{16'h1C8A, 16'h7FFF, 16'h001F, 16'h0001, 16'h0000},
    '{16'h1C8A, 16'h801F, 16'h801F, 16'h0020, 16'h0000}, '{16'h1C88, 16'hFFEF, 16'h000F, 16'h0020, 16'h001F},
    '{16'h1C88, 16'h0001, 16'h0001, 16'h0020, 16'h0000}, '{16'h1C8A, 16'h8004, 16'h8004, 16'h0005, 16'h0000},
    '{16'h1C88, 16'h0010, 16'h0010, 16'h0005, 16'h0000}, '{16'h1C88, 16'h0002, 16'h0002, 16'h0005, 16'h0012}};
  pll_multiplier_prescaler_regs u_pll_multiplier_prescaler_regs (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .io_addr_in(io_addr_in),
    .io_write_in(io_write_in),
    .io_wdata_in(io_wdata_in),
    .io_read_in(io_read_in),
    .io_rdata_out(io_rdata_out),
    .io_hit_out(io_hit_out),
    .pll_multiplier_select_out(pll_multiplier_select_out),
    .mult_code_valid_out(mult_code_valid_out),
    .prescaler_ratio_out(prescaler_ratio_out),
    .prescaler_enable_out(prescaler_enable_out),
    .prescale_divide_out(prescale_divide_out),
    .pll_factor_out(pll_factor_out)
  );
  task automatic chk(input logic [15:0] s, e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value at %0t: %h vs %h", $time, s, e);
    end
  endtask
  // The second edge keeps two accesses from touching the strobes in one step.
  task automatic acc(input logic [15:0] a, d, input logic w);
    {io_addr_in, io_wdata_in, io_write_in, io_read_in} = {a, d, w, !w};
    @(negedge sys_clk_in);
    {io_write_in, io_read_in} = 2'h0;
    @(negedge sys_clk_in);
  endtask
  task automatic print_verdict;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial forever #5 sys_clk_in = ~sys_clk_in;
  initial begin
    repeat (20) @(negedge sys_clk_in);
    rst_in = 1'h0;
    foreach (rows[i]) begin
      acc(rows[i][0], rows[i][1], 1'h1);
      chk({15'h0000, io_hit_out}, 16'h0001);
      chk({10'h000, prescale_divide_out}, rows[i][3]);
      chk({11'h000, mult_code_valid_out, pll_factor_out}, rows[i][4]);
      acc(rows[i][0], 16'h0000, 1'h0);
      chk(io_rdata_out, rows[i][2]);
    end
    $display("table done");
    acc(16'h1C8C, 16'hFFFF, 1'h1);
    chk({15'h0000, io_hit_out}, 16'h0000);
    acc(16'h1C8C, 16'h0000, 1'h0);
    chk(io_rdata_out, 16'h0000);
    acc(16'h1C8A, 16'h0000, 1'h0);
    chk(io_rdata_out, 16'h8004);
    $display("unmapped done");
    rst_in = 1'h1;
    repeat (2) @(negedge sys_clk_in);
    rst_in = 1'h0;
    acc(16'h1C8A, 16'h0000, 1'h0);
    chk(io_rdata_out, 16'h8000);
    chk({10'h000, prescale_divide_out}, 16'h0001);
    acc(16'h1C88, 16'h0000, 1'h0);
    chk(io_rdata_out, 16'h0000);
    chk({11'h000, mult_code_valid_out, pll_factor_out}, 16'h0000);
    acc(16'h1C88, 16'h000A, 1'h1);
    chk({11'h000, mult_code_valid_out, pll_factor_out}, 16'h001A);
    $display("reset done");
    print_verdict;
  end
endmodule
